// ===== pkg/pfs_pkg.sv
package pfs_pkg;
   // Register map of the control block (word offsets as byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_XTAL = 8'h04;
   localparam logic [7:0] ADDR_LOOP2 = 8'h08;
   localparam logic [7:0] ADDR_LOOP3 = 8'h0c;
   localparam logic [7:0] ADDR_DIVA = 8'h10;
   localparam logic [7:0] ADDR_DIVB = 8'h14;
   localparam logic [7:0] ADDR_TABLE0 = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h40;
   localparam int TABLE_ROWS = 8;
   // Crystal load: 6 pF at code 0, 0.375 pF per step, in units of 1/1000 pF
   localparam logic [15:0] CAP_MIN_MPF = 16'h1770;
   localparam logic [15:0] CAP_STEP_MPF = 16'h0177;
   // Output E post-divider codes
   localparam logic [1:0] POST_OFF = 2'h0;
   localparam logic [1:0] POST_DIV4 = 2'h1;
   localparam logic [1:0] POST_DIV2 = 2'h2;
   localparam logic [1:0] POST_DIV3 = 2'h3;

   typedef struct packed {
      logic [10:0] p;
      logic [7:0] q;
   } pfs_loop_s;

   typedef struct packed {
      logic bank;
      pfs_loop_s loop;
   } pfs_row_s;

   typedef struct packed {
      logic full_shutdown;
      logic sel2_is_suspend;
      logic [1:0] post_div;
      logic [2:0] suspend_out_mask;
      logic [1:0] suspend_loop_mask;
   } pfs_ctrl_s;

   typedef struct packed {
      logic bypass;
      logic [1:0] drive;
      logic [5:0] cap_code;
   } pfs_xtal_s;

   typedef enum logic [1:0] {
      PFS_SAMPLE = 2'b00,
      PFS_RUN = 2'b01
   } pfs_state_e;
endpackage

// ===== hdl/pfs_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Serial data and clock pin levels are latched once at start-up as select bits.
// - Low enable pin with full shutdown tristates outputs and powers down chip.
// - Otherwise a low enable pin only tristates outputs; chip keeps running.
// - Third select pin is frequency bit 2, or suspend input if configured.
// - Each loop gets an 8-bit reference divider and 11-bit feedback value.
// - First loop feeds a divide by 2, 3 or 4 post-divider for output E.
// - First loop setting comes from programming and from the select inputs.
// - Second and third loops use programmed settings only.
// - Select bit 2 switches first loop and bank select together; output A and B dividers follow one cycle later.
// - Eight-row table of first loop divider pairs indexed by select bits.
// - Outputs A and B each have two 7-bit dividers under one shared select.
// - Each table row stores which A/B divider register it selects.
// - Divider changes from select bit 2 are glitch free.
// - Six-bit load capacitance code, 0.375 pF steps, 6 pF to 29.625 pF.
// - Bypass setting removes load capacitors for driven references.
// - Oscillator drive strength is a programmable setting.
// - Divider bank select is taken from the chosen table row.
// - Suspend mode low shuts down a programmed set of outputs and loops.
module pfs_ctrl (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic serial_data_pin,
   input wire logic serial_clock_pin,
   input wire logic live_select_bit2,
   input wire logic shutdown_oe_n,
   input wire logic ref_clk_tick,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output pfs_pkg::pfs_loop_s first_synth_loop,
   output pfs_pkg::pfs_loop_s second_synth_loop,
   output pfs_pkg::pfs_loop_s third_synth_loop,
   output logic [2:0] loop_enable,
   output logic [6:0] div_a,
   output logic [6:0] div_b,
   output logic divider_bank_select,
   output logic [2:0] out_enable,
   output logic output_clock_e,
   output logic chip_powered,
   output logic [5:0] cap_code,
   output logic [15:0] cap_load_mpf,
   output logic cap_bypass,
   output logic [1:0] osc_drive
);
   // Two-flop synchronisers for every pin input
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic latched_select_bit0;
   logic latched_select_bit1;
   pfs_pkg::pfs_state_e state;
   pfs_pkg::pfs_ctrl_s ctrl;
   pfs_pkg::pfs_xtal_s xtal;
   pfs_pkg::pfs_loop_s loop2;
   pfs_pkg::pfs_loop_s loop3;
   logic [6:0] diva_reg [2];
   logic [6:0] divb_reg [2];
   pfs_pkg::pfs_row_s table_row [pfs_pkg::TABLE_ROWS];
   logic [1:0] post_cnt;
   logic tick_prev;

   // Kept out of reset: the straps must already stand in both stages when reset lifts
   always_ff @(posedge sys_clk) begin
      pin_meta <= {ref_clk_tick, shutdown_oe_n, live_select_bit2, serial_data_pin};
      pin_sync <= pin_meta;
   end

   // Extra synchroniser pair for the serial clock pin
   logic [1:0] sclk_sync;
   always_ff @(posedge sys_clk) begin
      sclk_sync <= {sclk_sync[0], serial_clock_pin};
   end

   wire sel0_pin = pin_sync[0];
   wire sel2_pin = pin_sync[1];
   wire oe_pin = pin_sync[2];
   wire tick_pin = pin_sync[3];
   wire sclk_pin = sclk_sync[1];

   // Start-up sampling: pins are captured once after reset release, then frozen
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= pfs_pkg::PFS_SAMPLE;
         latched_select_bit0 <= 1'b0;
         latched_select_bit1 <= 1'b0;
      end else if (state == pfs_pkg::PFS_SAMPLE) begin
         latched_select_bit0 <= sel0_pin;
         latched_select_bit1 <= sclk_pin;
         state <= pfs_pkg::PFS_RUN;
      end
   end

   // Register decode
   wire wr_ctrl = reg_wr && reg_addr == pfs_pkg::ADDR_CTRL;
   wire wr_xtal = reg_wr && reg_addr == pfs_pkg::ADDR_XTAL;
   wire wr_l2 = reg_wr && reg_addr == pfs_pkg::ADDR_LOOP2;
   wire wr_l3 = reg_wr && reg_addr == pfs_pkg::ADDR_LOOP3;
   wire wr_da = reg_wr && reg_addr == pfs_pkg::ADDR_DIVA;
   wire wr_db = reg_wr && reg_addr == pfs_pkg::ADDR_DIVB;

   function automatic logic table_hit(input logic [7:0] a, input int r);
      return a == pfs_pkg::ADDR_TABLE0 + 8'((r) * 4);
   endfunction

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl <= '0;
         xtal <= '0;
         loop2 <= '0;
         loop3 <= '0;
      end else begin
         if (wr_ctrl) ctrl <= pfs_pkg::pfs_ctrl_s'(reg_wdata[8:0]);
         if (wr_xtal) xtal <= pfs_pkg::pfs_xtal_s'(reg_wdata[8:0]);
         if (wr_l2) loop2 <= pfs_pkg::pfs_loop_s'(reg_wdata[18:0]);
         if (wr_l3) loop3 <= pfs_pkg::pfs_loop_s'(reg_wdata[18:0]);
      end
   end

   // Two divider registers each for A and B; bit 8 of the data picks which
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_div
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               diva_reg[gi] <= 7'h01;
               divb_reg[gi] <= 7'h01;
            end else begin
               if (wr_da && reg_wdata[8] == gi[0]) diva_reg[gi] <= reg_wdata[6:0];
               if (wr_db && reg_wdata[8] == gi[0]) divb_reg[gi] <= reg_wdata[6:0];
            end
         end
      end
      for (gi = 0; gi < pfs_pkg::TABLE_ROWS; gi++) begin : g_row
         always_ff @(posedge sys_clk) begin
            if (sys_rst) table_row[gi] <= '0;
            else if (reg_wr && table_hit(reg_addr, gi))
               table_row[gi] <= pfs_pkg::pfs_row_s'(reg_wdata[19:0]);
         end
      end
   endgenerate

   // Row selection; in suspend mode the pin no longer indexes the table
   wire bit2 = ctrl.sel2_is_suspend ? 1'b0 : sel2_pin;
   wire [2:0] row_idx = {bit2, latched_select_bit1, latched_select_bit0};
   wire pfs_pkg::pfs_row_s row = table_row[row_idx];
   wire suspended = ctrl.sel2_is_suspend && !sel2_pin;
   wire oe_low = !oe_pin;
   wire full_off = oe_low && ctrl.full_shutdown;
   wire running = state == pfs_pkg::PFS_RUN;

   wire [2:0] next_loop_enable = full_off ? 3'h0 :
                                 {~(suspended & ctrl.suspend_loop_mask[1]),
                                  ~(suspended & ctrl.suspend_loop_mask[0]), 1'b1};
   wire [2:0] next_out_enable = (oe_low || !running) ? 3'h0 :
                                ~({3{suspended}} & ctrl.suspend_out_mask);
   wire [15:0] next_cap = pfs_pkg::CAP_MIN_MPF
                          + 16'(xtal.cap_code * pfs_pkg::CAP_STEP_MPF);

   // Bank changes only on the output E divider wrap or while output E is off, so dividers swap at a clean point
   wire post_wrap = post_cnt == 2'h0;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         divider_bank_select <= 1'b0;
         first_synth_loop <= '0;
      end else if (post_wrap || ctrl.post_div == pfs_pkg::POST_OFF) begin
         divider_bank_select <= row.bank;
         first_synth_loop <= row.loop;
      end
   end

   // Post-divider for output E driven from the first-loop tick
   wire tick_rise = tick_pin && !tick_prev;
   wire [1:0] post_last = ctrl.post_div == pfs_pkg::POST_DIV4 ? 2'h3 :
                          ctrl.post_div == pfs_pkg::POST_DIV3 ? 2'h2 : 2'h1;
   wire [1:0] next_post_cnt = post_cnt >= post_last ? 2'h0 : post_cnt + 2'h1;
   // High for the first half of each period; three bits so the divide by 4 does not wrap
   wire [2:0] post_half = ({1'b0, post_last} + 3'h1) >> 1;
   wire next_clock_e = {1'b0, next_post_cnt} < post_half;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tick_prev <= 1'b0;
         post_cnt <= 2'h0;
         output_clock_e <= 1'b0;
      end else begin
         tick_prev <= tick_pin;
         if (tick_rise && ctrl.post_div != pfs_pkg::POST_OFF && next_loop_enable[0]) begin
            post_cnt <= next_post_cnt;
            output_clock_e <= next_clock_e;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         second_synth_loop <= '0;
         third_synth_loop <= '0;
         loop_enable <= 3'h0;
         out_enable <= 3'h0;
         div_a <= 7'h01;
         div_b <= 7'h01;
         chip_powered <= 1'b0;
         cap_code <= 6'h00;
         cap_load_mpf <= pfs_pkg::CAP_MIN_MPF;
         cap_bypass <= 1'b0;
         osc_drive <= 2'h0;
      end else begin
         second_synth_loop <= loop2;
         third_synth_loop <= loop3;
         loop_enable <= next_loop_enable;
         out_enable <= next_out_enable;
         div_a <= diva_reg[divider_bank_select];
         div_b <= divb_reg[divider_bank_select];
         chip_powered <= !full_off;
         cap_code <= xtal.cap_code;
         cap_load_mpf <= xtal.bypass ? 16'h0000 : next_cap;
         cap_bypass <= xtal.bypass;
         osc_drive <= xtal.drive;
      end
   end

   // Read mux; unmapped addresses read zero
   wire [31:0] rd_mux =
      reg_addr == pfs_pkg::ADDR_CTRL ? {23'h0, ctrl} :
      reg_addr == pfs_pkg::ADDR_XTAL ? {23'h0, xtal} :
      reg_addr == pfs_pkg::ADDR_LOOP2 ? {13'h0, loop2} :
      reg_addr == pfs_pkg::ADDR_LOOP3 ? {13'h0, loop3} :
      reg_addr == pfs_pkg::ADDR_STATUS ? {25'h0, divider_bank_select, row_idx,
                                          suspended, full_off, running} : 32'h0;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) reg_rdata <= 32'h0;
      else if (reg_rd) reg_rdata <= rd_mux;
      else reg_rdata <= 32'h0;
   end

   // Checks
   property p_latch_frozen;
      @(posedge sys_clk) disable iff (sys_rst)
      $past(running) |-> $stable(latched_select_bit0) && $stable(latched_select_bit1);
   endproperty
   a_latch_frozen: assert property (p_latch_frozen) else $error("select latch moved");

   property p_full_off;
      @(posedge sys_clk) disable iff (sys_rst)
      full_off |=> !chip_powered && out_enable == 3'h0 && loop_enable == 3'h0;
   endproperty
   a_full_off: assert property (p_full_off) else $error("shutdown incomplete");

   property p_oe_only;
      @(posedge sys_clk) disable iff (sys_rst)
      oe_low && !ctrl.full_shutdown |=> chip_powered && out_enable == 3'h0;
   endproperty
   a_oe_only: assert property (p_oe_only) else $error("oe-only mode wrong");

   property p_suspend;
      @(posedge sys_clk) disable iff (sys_rst)
      suspended && !oe_low && running |=> (out_enable & $past(ctrl.suspend_out_mask)) == 3'h0;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend mask ignored");

   property p_index;
      @(posedge sys_clk) disable iff (sys_rst)
      row_idx[1:0] == {latched_select_bit1, latched_select_bit0} &&
      (ctrl.sel2_is_suspend || row_idx[2] == sel2_pin);
   endproperty
   a_index: assert property (p_index) else $error("row index wrong");

   property p_bank_glitchfree;
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(divider_bank_select) |->
      $past(post_wrap) || $past(ctrl.post_div) == pfs_pkg::POST_OFF;
   endproperty
   a_bank_glitchfree: assert property (p_bank_glitchfree) else $error("bank swap mid-cycle");

   // Output E holds still while its divider is switched off
   property p_post_off;
      @(posedge sys_clk) disable iff (sys_rst)
      ctrl.post_div == pfs_pkg::POST_OFF |=> $stable(output_clock_e);
   endproperty
   a_post_off: assert property (p_post_off) else $error("output E moved while off");

   sequence s_cap_steady;
      !xtal.bypass ##1 !xtal.bypass;
   endsequence

   property p_cap;
      @(posedge sys_clk) disable iff (sys_rst)
      s_cap_steady |->
      cap_load_mpf == pfs_pkg::CAP_MIN_MPF + 16'($past(xtal.cap_code) * pfs_pkg::CAP_STEP_MPF);
   endproperty
   a_cap: assert property (p_cap) else $error("load cap wrong");

   property p_bypass;
      @(posedge sys_clk) disable iff (sys_rst)
      xtal.bypass |=> cap_bypass && cap_load_mpf == 16'h0000;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass wrong");

   property p_loop2;
      @(posedge sys_clk) disable iff (sys_rst)
      wr_l2 |=> ##1 second_synth_loop == $past(reg_wdata[18:0], 2);
   endproperty
   a_loop2: assert property (p_loop2) else $error("loop2 not programmed");
endmodule

// ===== verif/pfs_board.sv
`timescale 1ns/1ps
// Board side: strap levels, select and enable pins, and a slow reference tick
module pfs_board (
   input wire logic sys_clk,
   input wire logic strap_hold,
   input wire logic [1:0] strap_bits,
   input wire logic sel2_lvl,
   input wire logic oe_n_lvl,
   input wire logic tick_run,
   output logic serial_data_pin,
   output logic serial_clock_pin,
   output logic live_select_bit2,
   output logic shutdown_oe_n,
   output logic ref_clk_tick
);
   logic [1:0] tick_cnt;
   logic bus_phase;
   initial begin
      {serial_data_pin, serial_clock_pin, live_select_bit2, ref_clk_tick} = 4'h0;
      shutdown_oe_n = 1'b1;
      tick_cnt = 2'h0;
      bus_phase = 1'b0;
   end
   // Straps stand through start-up; later the shared pins carry bus traffic
   always @(posedge sys_clk) begin
      bus_phase <= ~bus_phase;
      serial_data_pin <= strap_hold ? strap_bits[0] : bus_phase;
      serial_clock_pin <= strap_hold ? strap_bits[1] : ~bus_phase;
      live_select_bit2 <= sel2_lvl;
      shutdown_oe_n <= oe_n_lvl;
   end
   // Tick toggles every third cycle, slow enough for the sync stages
   always @(posedge sys_clk) begin
      if (!tick_run || tick_cnt == 2'h2) begin
         tick_cnt <= 2'h0;
      end else begin
         tick_cnt <= tick_cnt + 2'h1;
      end
      if (tick_run && tick_cnt == 2'h2) begin
         ref_clk_tick <= ~ref_clk_tick;
      end
   end
endmodule

// ===== verif/pfs_ctrl_bench.sv
`timescale 1ns/1ps
module pfs_ctrl_bench;
   logic sys_clk, sys_rst, reg_wr, reg_rd, strap_hold, sel2_lvl, oe_n_lvl, tick_run;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   integer seed;
   logic [1:0] strap_bits, drive;
   logic data_pin, sclk, sel2, oe_n, tick, bank, clk_e, powered, bypass;
   pfs_pkg::pfs_loop_s loop1, loop2, loop3;
   logic [2:0] loop_en, out_en;
   logic [6:0] div_a, div_b;
   logic [5:0] cap;
   logic [15:0] cap_mpf;
   pfs_pkg::pfs_row_s rows [8];
   logic [6:0] dv [2][2];
   int fail_count, cmp_count;
   int cycles = 0;
   pfs_board board (.sys_clk(sys_clk), .strap_hold(strap_hold), .strap_bits(strap_bits),
      .sel2_lvl(sel2_lvl), .oe_n_lvl(oe_n_lvl), .tick_run(tick_run),
      .serial_data_pin(data_pin), .serial_clock_pin(sclk), .live_select_bit2(sel2),
      .shutdown_oe_n(oe_n), .ref_clk_tick(tick));
   pfs_ctrl DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .serial_data_pin(data_pin),
      .serial_clock_pin(sclk), .live_select_bit2(sel2), .shutdown_oe_n(oe_n),
      .ref_clk_tick(tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_synth_loop(loop1),
      .second_synth_loop(loop2), .third_synth_loop(loop3), .loop_enable(loop_en),
      .div_a(div_a), .div_b(div_b), .divider_bank_select(bank), .out_enable(out_en),
      .output_clock_e(clk_e), .chip_powered(powered), .cap_code(cap),
      .cap_load_mpf(cap_mpf), .cap_bypass(bypass), .osc_drive(drive));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic finish_test();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bus cycles: one strobe cycle each; read data is taken in the following cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Load in thousandths of a pF: 6 pF plus 0.375 pF per code step, none when bypassed
   function automatic logic [31:0] exp_cap(input logic [8:0] v);
      return v[8] ? 32'h0 : 32'h1770 + 32'h0177 * {26'h0, v[5:0]};
   endfunction
   // Everything steered by the table row follows the row that idx names
   task automatic check_row(input logic [2:0] idx);
      chk(loop1, rows[idx].loop, "first_loop");
      chk(bank, rows[idx].bank, "bank_sel");
      chk(div_a, dv[rows[idx].bank][0], "div_a");
      chk(div_b, dv[rows[idx].bank][1], "div_b");
      rd(pfs_pkg::ADDR_STATUS);
      chk(rd_val[5:3], idx, "row_idx");
   endtask
   // Timeout: the whole sequence needs about 1100 cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      logic [31:0] tmp;
      logic [8:0] x;
      int edges, prev, ex;
      seed = 32'ha70f;
      {sys_rst, strap_hold, oe_n_lvl} = 3'h7;
      {reg_wr, reg_rd, sel2_lvl, tick_run} = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      {fail_count, cmp_count} = '0;
      strap_bits = 2'($random(seed));
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      hold(1);
      chk(div_a, 32'h1, "div_a_reset");
      chk(cap_mpf, 32'h1770, "cap_reset");
      hold(6);
      @(posedge sys_clk);
      strap_hold <= 1'b0;
      for (int r = 0; r < 8; r++) begin
         rows[r] = 20'($random(seed));
         wr(pfs_pkg::ADDR_TABLE0 + 8'(4 * r), {12'h0, rows[r]});
      end
      for (int b = 0; b < 2; b++) begin
         for (int s = 0; s < 2; s++) begin
            dv[b][s] = 7'($random(seed));
            wr(s ? pfs_pkg::ADDR_DIVB : pfs_pkg::ADDR_DIVA, {23'h0, b[0], 1'b0, dv[b][s]});
         end
      end
      wr(pfs_pkg::ADDR_CTRL, 32'h0);
      // Bit 2 flips while the latched straps see constant bus traffic
      for (int k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         sel2_lvl <= k[0];
         hold(8);
         check_row({k[0], strap_bits});
      end
      rows[{1'b1, strap_bits}] = 20'($random(seed));
      wr(pfs_pkg::ADDR_TABLE0 + {3'h1, strap_bits, 2'h0}, {12'h0, rows[{1'b1, strap_bits}]});
      hold(4);
      check_row({1'b1, strap_bits});
      tmp = $random(seed);
      wr(pfs_pkg::ADDR_LOOP2, {13'h0, tmp[18:0]});
      wr(pfs_pkg::ADDR_LOOP3, {13'h0, tmp[31:13]});
      @(posedge sys_clk);
      sel2_lvl <= 1'b0;
      hold(8);
      chk(loop2, tmp[18:0], "loop2");
      chk(loop3, tmp[31:13], "loop3");
      // Crystal settings, both ends of the load code included
      for (int i = 0; i < 6; i++) begin
         x = 9'($random(seed));
         x[5:0] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : x[5:0];
         wr(pfs_pkg::ADDR_XTAL, {23'h0, x});
         hold(4);
         chk(cap, x[5:0], "cap_code");
         chk(cap_mpf, exp_cap(x), "cap_mpf");
         chk(bypass, x[8], "bypass");
         chk(drive, x[7:6], "drive");
      end
      rd(pfs_pkg::ADDR_XTAL);
      chk(rd_val, {23'h0, x}, "xtal_read");
      rd(8'hfc);
      chk(rd_val, 32'h0, "unmapped_read");
      rd(pfs_pkg::ADDR_TABLE0);
      chk(rd_val, 32'h0, "table_read");
      // Enable pin low, with and without full shutdown
      for (int f = 0; f < 2; f++) begin
         wr(pfs_pkg::ADDR_CTRL, {23'h0, f[0], 8'h0});
         @(posedge sys_clk);
         oe_n_lvl <= 1'b0;
         hold(8);
         chk(out_en, 32'h0, "out_en_off");
         chk(powered, !f[0], "powered");
         chk(loop_en, f[0] ? 32'h0 : 32'h7, "loop_en_off");
         @(posedge sys_clk);
         oe_n_lvl <= 1'b1;
      end
      // Suspend role: bit 2 reads as zero and low suspends the masked set
      @(posedge sys_clk);
      sel2_lvl <= 1'b1;
      wr(pfs_pkg::ADDR_CTRL, 32'h96);
      hold(8);
      chk(loop1, rows[{1'b0, strap_bits}].loop, "suspend_row");
      @(posedge sys_clk);
      sel2_lvl <= 1'b0;
      hold(8);
      chk(out_en, 32'h2, "suspend_outs");
      chk(loop_en, 32'h3, "suspend_loops");
      // Output E: 48 reference ticks per divisor, one edge of slack
      @(posedge sys_clk);
      tick_run <= 1'b1;
      for (int d = 1; d < 4; d++) begin
         wr(pfs_pkg::ADDR_CTRL, {25'h0, d[1:0], 5'h0});
         hold(12);
         edges = 0;
         prev = clk_e;
         repeat (288) begin
            hold(1);
            edges += (clk_e === 1'b1 && prev == 0) ? 1 : 0;
            prev = clk_e;
         end
         ex = (d == 1) ? 12 : (d == 2) ? 24 : 16;
         chk(edges >= ex - 1 && edges <= ex + 1, 32'h1, "clock_e_edges");
      end
      finish_test();
   end
endmodule
